/* hw/i2ctrg_top.sv */
// passive i2c monitor: start, stop, nack, address and data triggers
// assumes scl and sda come straight from the observed bus pins
`include "i2ctrg_map.svh"

module i2ctrg_top
    import i2ctrg_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic        CLK_EN,
    // observed bus
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    // trigger selection
    input  wire logic [2:0]  TRIG_MODE,
    input  wire logic        ADDR_NACK_SELECT,
    input  wire logic        WRITE_DATA_NACK_SELECT,
    input  wire logic        READ_DATA_NACK_SELECT,
    // address condition
    input  wire logic        ADDRESS_WIDTH_SELECT,
    input  wire logic [1:0]  DIRECTION_SELECT,
    input  wire logic [1:0]  ADDRESS_CONDITION,
    input  wire logic [9:0]  ADDRESS_LOWER_BOUND,
    input  wire logic [9:0]  ADDRESS_UPPER_BOUND,
    // data condition
    input  wire logic [1:0]  DATA_COMPARE_CONDITION,
    input  wire logic [63:0] DATA_LOWER_PATTERN,
    input  wire logic [63:0] DATA_UPPER_PATTERN,
    input  wire logic [3:0]  DATA_PATTERN_BYTES,
    input  wire logic [7:0]  DATA_BYTE_SKIP_COUNT,
    // results
    output logic             TRIGGER,
    output logic             NACK_ERROR,
    output logic             BUS_OPEN
);

    i2ctrg_line_if line ();

    i2ctrg_sync u_sync (
        .clk     (CORE_CLK),
        .reset   (RESET),
        .clk_en  (CLK_EN),
        .scl_pin (SCL_IN),
        .sda_pin (SDA_IN),
        .line    (line)
    );

    i2ctrg_mon_s s;
    i2ctrg_mon_s next_s;

    function automatic logic cmp_ok(
        input logic [1:0] cond,
        input logic [9:0] v,
        input logic [9:0] lo,
        input logic [9:0] hi
    );
        logic inside_range;
        inside_range = (v >= lo) && (v <= hi);
        case (cond)
            `I2CTRG_CMP_EQUAL:     cmp_ok = (v == lo);
            `I2CTRG_CMP_IN_RANGE:  cmp_ok = inside_range;
            `I2CTRG_CMP_OUT_RANGE: cmp_ok = !inside_range;
            default:               cmp_ok = 1'b0;
        endcase
    endfunction

    logic [3:0] len_eff;
    logic [9:0] addr_mask;

    // zero pattern length is taken as one byte
    assign len_eff = (DATA_PATTERN_BYTES == 4'h0) ? 4'h1 :
                     (DATA_PATTERN_BYTES > `I2CTRG_PATTERN_BYTES) ?
                     `I2CTRG_PATTERN_BYTES : DATA_PATTERN_BYTES;
    assign addr_mask = ADDRESS_WIDTH_SELECT ? 10'h3FF : 10'h07F;

    always_comb begin
        logic [9:0] a_val;
        logic       a_done;
        logic       a_rnw;
        logic       a_match;
        logic       dir_ok;
        logic [2:0] pidx;
        logic [7:0] plo;
        logic [7:0] phi;
        logic       d_match;
        logic       nack_en;
        a_val   = 10'h000;
        a_done  = 1'b0;
        a_rnw   = 1'b0;
        a_match = 1'b0;
        dir_ok  = 1'b0;
        nack_en = 1'b0;
        // pattern bytes right aligned, first compared byte is the msb
        pidx    = 3'(len_eff - 4'h1 - s.match_cnt);
        plo     = DATA_LOWER_PATTERN[{pidx, 3'b000} +: 8];
        phi     = DATA_UPPER_PATTERN[{pidx, 3'b000} +: 8];
        d_match = cmp_ok(DATA_COMPARE_CONDITION, {2'b00, s.shift},
                         {2'b00, plo}, {2'b00, phi});
        next_s = s;
        next_s.trigger    = 1'b0;
        next_s.nack_error = 1'b0;
        if (CLK_EN) begin
            if (line.sda_fall && line.scl) begin
                // start or repeated start
                if (TRIG_MODE == `I2CTRG_MODE_START) begin
                    next_s.trigger = 1'b1;
                end
                if (TRIG_MODE == `I2CTRG_MODE_REPSTART && s.open) begin
                    next_s.trigger = 1'b1;
                end
                next_s.open      = 1'b1;
                next_s.active    = 1'b1;
                next_s.phase     = PH_ADDR1;
                next_s.bit_cnt   = 4'h0;
                next_s.addr_ok   = 1'b0;
                next_s.data_idx  = 8'h00;
                next_s.match_cnt = 4'h0;
                next_s.data_done = 1'b0;
            end else if (line.sda_rise && line.scl) begin
                if (TRIG_MODE == `I2CTRG_MODE_STOP) begin
                    next_s.trigger = 1'b1;
                end
                next_s.open    = 1'b0;
                next_s.active  = 1'b0;
                next_s.bit_cnt = 4'h0;
            end else if (s.active && line.scl_rise) begin
                if (s.bit_cnt < `I2CTRG_BITS_PER_BYTE) begin
                    next_s.shift   = {s.shift[6:0], line.sda};
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                end else if (s.bit_cnt == `I2CTRG_BITS_PER_BYTE) begin
                    next_s.bit_cnt = `I2CTRG_ACK_SLOT;
                    if (line.sda) begin
                        // ninth pulse saw sda high
                        case (s.phase)
                            PH_ADDR1,
                            PH_ADDR2: nack_en = ADDR_NACK_SELECT;
                            PH_DATA:  nack_en = s.rnw ?
                                                READ_DATA_NACK_SELECT :
                                                WRITE_DATA_NACK_SELECT;
                            default:  nack_en = 1'b0;
                        endcase
                        if (TRIG_MODE == `I2CTRG_MODE_NACK && nack_en) begin
                            next_s.trigger = 1'b1;
                        end
                        // read data nack ends a read normally
                        next_s.nack_error = !(s.phase == PH_DATA && s.rnw);
                    end
                end
            end else if (s.active && line.scl_fall &&
                         s.bit_cnt == `I2CTRG_ACK_SLOT) begin
                next_s.bit_cnt = 4'h0;
                case (s.phase)
                    PH_ADDR1: begin
                        next_s.rnw = s.shift[0];
                        a_rnw      = s.shift[0];
                        if (ADDRESS_WIDTH_SELECT) begin
                            if (s.shift[7:3] == `I2CTRG_HDR10) begin
                                next_s.addr_hi = s.shift[2:1];
                                if (s.shift[0]) begin
                                    // read header repeats stored low byte
                                    a_val        = {s.shift[2:1], s.addr_lo};
                                    a_done       = 1'b1;
                                    next_s.phase = PH_DATA;
                                end else begin
                                    next_s.phase = PH_ADDR2;
                                end
                            end else begin
                                next_s.phase = PH_DATA;
                            end
                        end else begin
                            a_val        = {3'b000, s.shift[7:1]};
                            a_done       = 1'b1;
                            next_s.phase = PH_DATA;
                        end
                    end
                    PH_ADDR2: begin
                        next_s.addr_lo = s.shift;
                        a_val          = {s.addr_hi, s.shift};
                        a_rnw          = s.rnw;
                        a_done         = 1'b1;
                        next_s.phase   = PH_DATA;
                    end
                    PH_DATA: begin
                        if (s.data_idx < DATA_BYTE_SKIP_COUNT) begin
                            next_s.data_idx = s.data_idx + 8'h01;
                        end else if (!s.data_done) begin
                            if (!d_match) begin
                                next_s.data_done = 1'b1;
                            end else if (s.match_cnt + 4'h1 == len_eff) begin
                                next_s.data_done = 1'b1;
                                if (TRIG_MODE == `I2CTRG_MODE_DATA) begin
                                    next_s.trigger = 1'b1;
                                end
                                if (TRIG_MODE == `I2CTRG_MODE_ADDR_DATA &&
                                    s.addr_ok) begin
                                    next_s.trigger = 1'b1;
                                end
                            end else begin
                                next_s.match_cnt = s.match_cnt + 4'h1;
                            end
                        end
                    end
                    default: begin
                        next_s.phase = PH_DATA;
                    end
                endcase
                if (a_done) begin
                    case (DIRECTION_SELECT)
                        `I2CTRG_DIR_EITHER: dir_ok = 1'b1;
                        `I2CTRG_DIR_READ:   dir_ok = a_rnw;
                        `I2CTRG_DIR_WRITE:  dir_ok = !a_rnw;
                        default:            dir_ok = 1'b0;
                    endcase
                    a_match = dir_ok &&
                              cmp_ok(ADDRESS_CONDITION, a_val & addr_mask,
                                     ADDRESS_LOWER_BOUND & addr_mask,
                                     ADDRESS_UPPER_BOUND & addr_mask);
                    if (a_match) begin
                        next_s.addr_ok = 1'b1;
                        if (TRIG_MODE == `I2CTRG_MODE_ADDR) begin
                            next_s.trigger = 1'b1;
                        end
                    end
                end
            end
        end else begin
            next_s.trigger    = s.trigger;
            next_s.nack_error = s.nack_error;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            s <= '{open: 1'b0, active: 1'b0, phase: PH_ADDR1,
                   bit_cnt: 4'h0, shift: 8'h00, rnw: 1'b0,
                   addr_lo: 8'h00, addr_hi: 2'h0, addr_ok: 1'b0,
                   data_idx: 8'h00, match_cnt: 4'h0, data_done: 1'b0,
                   trigger: 1'b0, nack_error: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign TRIGGER    = s.trigger;
    assign NACK_ERROR = s.nack_error;
    assign BUS_OPEN   = s.open;

endmodule

/* include/i2ctrg_map.svh */
// constants of the i2c protocol trigger: codes, field positions, resets
// assumes inclusion by bare name from the package and the design modules
//
// Contract
// - a falling sda while scl is high is a start, and start mode fires there.
// - repeated-start mode fires only on a start seen while a transfer is open.
// - a rising sda while scl is high is a stop, closing the message; stop mode fires.
// - sda high on the ninth scl pulse of a byte is a nack, and nack mode fires.
// - address, write-data and read-data nacks are enabled separately; read nack is no error.
// - address triggers fire at the scl fall that ends the acknowledge after the address.
// - the address width is 7 or 10 bits and the compare pattern follows it.
// - address matches are qualified by direction: read only, write only or either.
// - address compare is exact on the lower value, or in or out of lower..upper range.
// - the data pattern is up to 64 bits msb first, compared byte by byte by value or range.
// - a programmable count of data bytes after the address is skipped before comparing.
// - address-and-data mode fires only when both match within one message.
// - a 10-bit address byte opens with 11110, then two address msbs, then direction.
// - the direction bit reads 1 as read and 0 as write.
`ifndef I2CTRG_MAP_SVH
`define I2CTRG_MAP_SVH

// trigger modes
`define I2CTRG_MODE_START     3'h0
`define I2CTRG_MODE_REPSTART  3'h1
`define I2CTRG_MODE_STOP      3'h2
`define I2CTRG_MODE_NACK      3'h3
`define I2CTRG_MODE_ADDR      3'h4
`define I2CTRG_MODE_DATA      3'h5
`define I2CTRG_MODE_ADDR_DATA 3'h6

// compare conditions
`define I2CTRG_CMP_EQUAL      2'h0
`define I2CTRG_CMP_IN_RANGE   2'h1
`define I2CTRG_CMP_OUT_RANGE  2'h2

// direction qualifier
`define I2CTRG_DIR_EITHER     2'h0
`define I2CTRG_DIR_READ       2'h1
`define I2CTRG_DIR_WRITE      2'h2

// byte layout
`define I2CTRG_HDR10          5'h1E
`define I2CTRG_BITS_PER_BYTE  4'h8
`define I2CTRG_ACK_SLOT       4'h9
`define I2CTRG_PATTERN_BITS   64
`define I2CTRG_PATTERN_BYTES  4'h8
`define I2CTRG_SYNC_RESET     2'h3

`endif

/* include/i2ctrg_pkg.sv */
// types shared by the i2c protocol trigger modules
// assumes the map header is on the include path
`include "i2ctrg_map.svh"

package i2ctrg_pkg;

    typedef enum logic [1:0] {
        PH_ADDR1,
        PH_ADDR2,
        PH_DATA
    } i2ctrg_phase_e;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stage;
        logic [1:0] prev;
    } i2ctrg_sync_s;

    typedef struct packed {
        logic          open;
        logic          active;
        i2ctrg_phase_e phase;
        logic [3:0]    bit_cnt;
        logic [7:0]    shift;
        logic          rnw;
        logic [7:0]    addr_lo;
        logic [1:0]    addr_hi;
        logic          addr_ok;
        logic [7:0]    data_idx;
        logic [3:0]    match_cnt;
        logic          data_done;
        logic          trigger;
        logic          nack_error;
    } i2ctrg_mon_s;

endpackage

/* include/i2ctrg_line_if.sv */
// sampled bus line state passed from the synchroniser to the monitor
// assumes both ends run on the monitor clock
interface i2ctrg_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;

    modport drv (
        output scl,
        output sda,
        output scl_rise,
        output scl_fall,
        output sda_rise,
        output sda_fall
    );

    modport mon (
        input  scl,
        input  sda,
        input  scl_rise,
        input  scl_fall,
        input  sda_rise,
        input  sda_fall
    );
endinterface

/* hw/i2ctrg_sync.sv */
// two-flop synchroniser and edge detector for scl and sda
// assumes pins are asynchronous to the clock and idle high
`include "i2ctrg_map.svh"

module i2ctrg_sync
    import i2ctrg_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // bus pins, observed only
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    // sampled lines
    i2ctrg_line_if.drv line
);

    i2ctrg_sync_s s;
    i2ctrg_sync_s next_s;

    always_comb begin
        next_s = s;
        if (clk_en) begin
            next_s.meta  = {scl_pin, sda_pin};
            next_s.stage = s.meta;
            next_s.prev  = s.stage;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '{meta: `I2CTRG_SYNC_RESET, stage: `I2CTRG_SYNC_RESET,
                   prev: `I2CTRG_SYNC_RESET};
        end else begin
            s <= next_s;
        end
    end

    // edges from second and third stages only
    assign line.scl      = s.stage[1];
    assign line.sda      = s.stage[0];
    assign line.scl_rise = clk_en & s.stage[1] & ~s.prev[1];
    assign line.scl_fall = clk_en & ~s.stage[1] & s.prev[1];
    assign line.sda_rise = clk_en & s.stage[0] & ~s.prev[0];
    assign line.sda_fall = clk_en & ~s.stage[0] & s.prev[0];

endmodule

/* bench/i2ctrg_sva.sv */
// assertion checker bound to the i2c trigger top
// assumes pins move at least two cycles apart
`include "i2ctrg_map.svh"

module i2ctrg_sva (
    // clock, reset, bus
    input wire logic       CORE_CLK,
    input wire logic       RESET,
    input wire logic       CLK_EN,
    input wire logic       SCL_IN,
    input wire logic       SDA_IN,
    input wire logic [2:0] TRIG_MODE,
    // results
    input wire logic       TRIGGER,
    input wire logic       NACK_ERROR,
    input wire logic       BUS_OPEN
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    sequence start_ev;
        CLK_EN && SCL_IN && $fell(SDA_IN);
    endsequence

    sequence stop_ev;
        CLK_EN && SCL_IN && $rose(SDA_IN);
    endsequence

    a_start_fires: assert property (
        (TRIG_MODE == `I2CTRG_MODE_START) ##0 start_ev |-> ##[2:6] TRIGGER)
        else $error("start without trigger");
    a_start_opens: assert property (
        start_ev |-> ##[2:6] BUS_OPEN)
        else $error("start did not open bus");
    a_rep_fires: assert property (
        (TRIG_MODE == `I2CTRG_MODE_REPSTART && BUS_OPEN) ##0 start_ev
        |-> ##[2:6] TRIGGER)
        else $error("repeated start without trigger");
    a_rep_quiet: assert property (
        (TRIG_MODE == `I2CTRG_MODE_REPSTART && !BUS_OPEN) ##0 start_ev
        |-> !TRIGGER [*6])
        else $error("first start fired in repeat mode");
    a_stop_fires: assert property (
        (TRIG_MODE == `I2CTRG_MODE_STOP) ##0 stop_ev |-> ##[2:6] TRIGGER)
        else $error("stop without trigger");
    a_stop_closes: assert property (
        stop_ev |-> ##[2:6] !BUS_OPEN)
        else $error("stop did not close bus");
    a_trig_pulse: assert property (
        TRIGGER && CLK_EN |=> !TRIGGER)
        else $error("trigger longer than a cycle");
    a_nack_pulse: assert property (
        NACK_ERROR && CLK_EN |=> !NACK_ERROR)
        else $error("nack error longer than a cycle");
endmodule

bind i2ctrg_top i2ctrg_sva i_sva (
    .CORE_CLK, .RESET, .CLK_EN, .SCL_IN, .SDA_IN,
    .TRIG_MODE, .TRIGGER, .NACK_ERROR, .BUS_OPEN
);

/* bench/i2ctrg_bus_model.sv */
// bus model: controller and target sharing scl and sda
// assumes pulled-up lines, moved just after rising clock edges
module i2ctrg_bus_model (
    // clock
    input wire logic clk,
    // bus lines
    output logic     scl,
    output logic     sda
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // also a repeated start when scl is low
    task automatic put_start;
        sda <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda <= 1'b0;
        hold(4);
        scl <= 1'b0;
        hold(4);
    endtask

    // ends with idle lines
    task automatic put_stop;
        sda <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda <= 1'b1;
        hold(8);
    endtask

    // msb first, then the acknowledge slot
    task automatic put_byte(input logic [7:0] b, input logic nack);
        for (int i = 0; i < 9; i++) begin
            sda <= (i < 8) ? b[7 - i] : nack;
            hold(4);
            scl <= 1'b1;
            hold(4);
            scl <= 1'b0;
            hold(4);
        end
    endtask
endmodule

/* bench/tb_top.sv */
// bench for the i2c trigger: start, stop, nack, address, data
// assumes the bus model drives the lines and the checker is bound
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        reset;
    logic        scl;
    logic        sda;
    logic [2:0]  mode;
    logic [2:0]  nsel;
    logic        wid;
    logic [1:0]  dir;
    logic [1:0]  acnd;
    logic [9:0]  alo;
    logic [9:0]  ahi;
    logic [1:0]  dcnd;
    logic [63:0] dlo;
    logic [63:0] dhi;
    logic [7:0]  skip;
    logic        en;
    logic [3:0]  pbytes;
    logic        trig;
    logic        nerr;
    logic        open_q;
    logic [7:0]  tcnt;
    logic [7:0]  ncnt;
    int          miscompares;
    int          checked;

    i2ctrg_top i_dut (
        .CORE_CLK(clk), .RESET(reset), .CLK_EN(en),
        .SCL_IN(scl), .SDA_IN(sda), .TRIG_MODE(mode),
        .ADDR_NACK_SELECT(nsel[0]),
        .WRITE_DATA_NACK_SELECT(nsel[1]),
        .READ_DATA_NACK_SELECT(nsel[2]),
        .ADDRESS_WIDTH_SELECT(wid), .DIRECTION_SELECT(dir),
        .ADDRESS_CONDITION(acnd), .ADDRESS_LOWER_BOUND(alo),
        .ADDRESS_UPPER_BOUND(ahi), .DATA_COMPARE_CONDITION(dcnd),
        .DATA_LOWER_PATTERN(dlo), .DATA_UPPER_PATTERN(dhi),
        .DATA_PATTERN_BYTES(pbytes), .DATA_BYTE_SKIP_COUNT(skip),
        .TRIGGER(trig), .NACK_ERROR(nerr), .BUS_OPEN(open_q)
    );

    i2ctrg_bus_model i_bus (.clk(clk), .scl(scl), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulse counters
    always @(posedge clk) begin
        if (reset) begin
            tcnt <= 8'h00;
            ncnt <= 8'h00;
        end else begin
            if (trig === 1'b1) tcnt <= tcnt + 8'h01;
            if (nerr === 1'b1) ncnt <= ncnt + 8'h01;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cfg(input logic [2:0] m, input logic w,
                       input logic [1:0] d, input logic [1:0] ac,
                       input logic [9:0] lo, input logic [9:0] hi);
        @(posedge clk);
        mode <= m;
        wid <= w;
        dir <= d;
        acnd <= ac;
        alo <= lo;
        ahi <= hi;
    endtask

    task automatic dcfg(input logic [1:0] c, input logic [63:0] lo,
                        input logic [63:0] hi, input logic [7:0] sk);
        @(posedge clk);
        dcnd <= c;
        dlo <= lo;
        dhi <= hi;
        skip <= sk;
    endtask

    // one message of n acked bytes, then the trigger count
    task automatic msg(input int n, input logic [31:0] b,
                       input logic [7:0] exp);
        logic [7:0] t0;
        t0 = tcnt;
        i_bus.put_start();
        for (int i = 0; i < n; i++) begin
            i_bus.put_byte(b[31 - 8 * i -: 8], 1'b0);
        end
        i_bus.put_stop();
        check({56'h0, tcnt - t0}, {56'h0, exp});
    endtask

    // modes start, repeated start, stop in turn
    task automatic sc_start_stop;
        logic [7:0] t0;
        for (int k = 0; k < 3; k++) begin
            cfg(3'(k), 1'b0, 2'h0, 2'h0, 10'h0, 10'h0);
            t0 = tcnt;
            i_bus.put_start();
            check({63'h0, open_q}, 64'h1);
            i_bus.put_start();
            i_bus.put_stop();
            check({63'h0, open_q}, 64'h0);
            check({56'h0, tcnt - t0}, (k == 0) ? 64'h2 : 64'h1);
        end
        $display("start stop test done");
    endtask

    // enable low: a whole message passes unseen
    task automatic sc_enable;
        logic [7:0] t0;
        cfg(3'h0, 1'b0, 2'h0, 2'h0, 10'h0, 10'h0);
        en <= 1'b0;
        t0 = tcnt;
        i_bus.put_start();
        i_bus.put_stop();
        en <= 1'b1;
        repeat (6) @(posedge clk);
        check({56'h0, tcnt - t0}, 64'h0);
        check({63'h0, open_q}, 64'h0);
        $display("enable test done");
    endtask

    // one nack class enabled at a time
    task automatic sc_nack;
        logic [7:0] t0;
        logic [7:0] n0;
        for (int k = 0; k < 3; k++) begin
            cfg(3'h3, 1'b0, 2'h0, 2'h0, 10'h0, 10'h0);
            nsel <= 3'b001 << k;
            t0 = tcnt;
            n0 = ncnt;
            i_bus.put_start();
            i_bus.put_byte(8'hA0, 1'b1);
            i_bus.put_byte(8'h11, 1'b1);
            i_bus.put_start();
            i_bus.put_byte(8'hA1, 1'b0);
            i_bus.put_byte(8'h22, 1'b1);
            i_bus.put_stop();
            check({56'h0, tcnt - t0}, 64'h1);
            check({56'h0, ncnt - n0}, 64'h2);
        end
        $display("nack test done");
    endtask

    task automatic sc_addr;
        logic [7:0] t0;
        cfg(3'h4, 1'b0, 2'h0, 2'h0, 10'h02A, 10'h0);
        msg(1, 32'h55000000, 8'h01);
        msg(1, 32'h56000000, 8'h00);
        cfg(3'h4, 1'b0, 2'h2, 2'h1, 10'h010, 10'h020);
        msg(1, 32'h40000000, 8'h01);
        msg(1, 32'h41000000, 8'h00);
        cfg(3'h4, 1'b0, 2'h1, 2'h2, 10'h010, 10'h020);
        msg(1, 32'h43000000, 8'h01);
        msg(1, 32'h21000000, 8'h00);
        cfg(3'h4, 1'b1, 2'h0, 2'h0, 10'h2A5, 10'h0);
        msg(2, 32'hF4A50000, 8'h01);
        msg(1, 32'h55000000, 8'h00);
        // read header after repeated start reuses the stored low byte
        cfg(3'h4, 1'b1, 2'h1, 2'h0, 10'h2A5, 10'h0);
        t0 = tcnt;
        i_bus.put_start();
        i_bus.put_byte(8'hF4, 1'b0);
        i_bus.put_byte(8'hA5, 1'b0);
        i_bus.put_start();
        i_bus.put_byte(8'hF5, 1'b0);
        i_bus.put_stop();
        check({56'h0, tcnt - t0}, 64'h1);
        $display("address test done");
    endtask

    task automatic sc_data;
        dcfg(2'h0, 64'h1234, 64'h0, 8'h01);
        cfg(3'h5, 1'b0, 2'h0, 2'h0, 10'h050, 10'h0);
        msg(4, 32'hA0991234, 8'h01);
        msg(4, 32'hA0991235, 8'h00);
        msg(4, 32'hA0123499, 8'h00);
        cfg(3'h6, 1'b0, 2'h0, 2'h0, 10'h050, 10'h0);
        msg(4, 32'hA0991234, 8'h01);
        cfg(3'h6, 1'b0, 2'h0, 2'h0, 10'h051, 10'h0);
        msg(4, 32'hA0991234, 8'h00);
        dcfg(2'h1, 64'h1030, 64'h2040, 8'h01);
        cfg(3'h5, 1'b0, 2'h0, 2'h0, 10'h050, 10'h0);
        msg(4, 32'hA0991234, 8'h01);
        dcfg(2'h2, 64'h1030, 64'h2040, 8'h01);
        msg(4, 32'hA0991234, 8'h00);
        dcfg(2'h0, 64'h34, 64'h0, 8'h02);
        pbytes <= 4'h1;
        msg(4, 32'hA0991234, 8'h01);
        msg(4, 32'hA0993412, 8'h00);
        $display("data test done");
    endtask

    initial begin
        reset = 1'b1;
        mode = 3'h7;
        nsel = 3'h0;
        wid = 1'b0;
        dir = 2'h0;
        acnd = 2'h0;
        alo = 10'h0;
        ahi = 10'h0;
        dcnd = 2'h0;
        dlo = 64'h0;
        dhi = 64'h0;
        skip = 8'h00;
        en = 1'b1;
        pbytes = 4'h2;
        miscompares = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        sc_start_stop();
        sc_enable();
        sc_nack();
        sc_addr();
        sc_data();
        complete_run();
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
